// ---- mapper_cfg_pkg.sv ----
// Constants for the mapper global and arbiter register bank.
// Assumes one 100 MHz system clock; register indices are word addresses.
`default_nettype none

package mapper_cfg_pkg;

	// ************************************************************
	// Register indices (byte address on the bus is four times these)
	// ************************************************************
	localparam logic [11:0] CHIP_ID_LOW_IDX = 12'h000;
	localparam logic [11:0] CHIP_ID_HIGH_IDX = 12'h001;
	localparam logic [11:0] GLOBAL_CONTROL_IDX = 12'h002;
	localparam logic [11:0] BERT_LINK_SELECT_IDX = 12'h003;
	localparam logic [11:0] LINE_CLOCK_ACTIVITY_IDX = 12'h004;
	localparam logic [11:0] SYSTEM_CLOCK_ACTIVITY_IDX = 12'h005;
	localparam logic [11:0] LINE_IRQ_ENABLE_IDX = 12'h006;
	localparam logic [11:0] LINE_IRQ_STATUS_IDX = 12'h007;
	localparam logic [11:0] ETHERNET_IRQ_ENABLE_IDX = 12'h008;
	localparam logic [11:0] ETHERNET_IRQ_STATUS_IDX = 12'h009;
	localparam logic [11:0] QUEUE_IRQ_ENABLE_IDX = 12'h00a;
	localparam logic [11:0] QUEUE_IRQ_STATUS_IDX = 12'h00b;
	localparam logic [11:0] PATTERN_TEST_IRQ_ENABLE_IDX = 12'h00c;
	localparam logic [11:0] PATTERN_TEST_IRQ_STATUS_IDX = 12'h00d;
	localparam logic [11:0] PORT_CONNECTION_IDX = 12'h00e;
	localparam logic [11:0] QUEUE_POINTER_RESET_IDX = 12'h012;
	localparam logic [11:0] MEMORY_SELFTEST_ENABLE_IDX = 12'h020;
	localparam logic [11:0] MEMORY_SELFTEST_RESULT_IDX = 12'h021;
	localparam logic [11:0] LINE_MODE_IDX = 12'h0e2;
	localparam logic [11:0] STRAP_STATUS_IDX = 12'h0e3;
	localparam logic [11:0] MAC_MODE_IDX = 12'h152;
	localparam logic [11:0] TOP_IDX = 12'h8ff;
	localparam logic [11:0] UNUSED_LOW_IDX = 12'h180;
	localparam logic [11:0] UNUSED_HIGH_IDX = 12'h7ff;
	localparam int SECTION_SHIFT = 6;

	// ************************************************************
	// Queue sizing registers: rx size, tx size, tx high, tx low,
	// rx low, rx high
	// ************************************************************
	localparam int QUEUE_REGS = 6;
	localparam logic [11:0] QUEUE_IDX [QUEUE_REGS] = '{
		12'h040, 12'h041, 12'h0e0, 12'h0e1, 12'h150, 12'h151};
	localparam logic [7:0] QUEUE_SET_A [QUEUE_REGS] = '{
		8'h2c, 8'h14, 8'h0c, 8'h06, 8'h0f, 8'h1e};
	localparam logic [7:0] QUEUE_SET_B [QUEUE_REGS] = '{
		8'h28, 8'h18, 8'h0c, 8'h06, 8'h0c, 8'h18};
	localparam logic [1:0] SELECT_SET_B = 2'h2;
	localparam int UNIT_SHIFT = 5;
	localparam int COUNT_W = 13;
	localparam int SLOT_BYTES = 2048;

	// ************************************************************
	// Reset and hardware-mode values
	// ************************************************************
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic PORT_CONNECTION_HW = 1'b1;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_IRQ_MASK_BIT = 1;
	localparam int CTRL_REFCLK_BIT = 2;
	localparam int LINE_LAPS_BIT = 0;
	localparam int LINE_SCRAMBLER_OFF_BIT = 1;
	localparam int LINE_BIT_REVERSE_BIT = 2;
	localparam int MAC_DUPLEX_BIT = 0;
	localparam int PORT_TX_BIT = 4;
	localparam int PORT_RX_BIT = 0;

endpackage : mapper_cfg_pkg

`default_nettype wire

// ---- mapper_global_config_regs.sv ----
// Global and arbiter register bank of the mapper with hardware-mode
// strap defaults, reached over an Avalon-MM slave with waitrequest.
// Assumes straps and event inputs are synchronous to CLK_SYS_IN.
`default_nettype none

module mapper_global_config_regs
	import mapper_cfg_pkg::*;
#(
	parameter logic [15:0] CHIP_ID = 16'h5a01 // Arbitrary value.
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	input wire logic [11:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic STRAP_CONFIG_ENABLE_IN,
	input wire logic [1:0] STRAP_DEFAULT_SELECT_IN,
	input wire logic REDUCED_MEDIA_IF_SELECT_IN,
	input wire logic LINE_ROLE_SELECT_IN,
	input wire logic DUPLEX_SELECT_IN,
	input wire logic LAPS_FRAMING_ENABLE_IN,
	input wire logic SCRAMBLER_DISABLE_IN,
	input wire logic BIT_ORDER_REVERSE_IN,
	input wire logic [7:0] LINE_CLOCK_ACTIVITY_IN,
	input wire logic [7:0] SYSTEM_CLOCK_ACTIVITY_IN,
	input wire logic [1:0] SELFTEST_RESULT_IN,
	input wire logic LINE_TX_EVENT_IN,
	input wire logic LINE_RX_EVENT_IN,
	input wire logic ETHERNET_EVENT_IN,
	input wire logic TX_QUEUE_EVENT_IN,
	input wire logic RX_QUEUE_EVENT_IN,
	input wire logic PATTERN_TEST_EVENT_IN,
	output logic IRQ_OUT,
	output logic HW_MODE_OUT,
	output logic SOFT_RESET_OUT,
	output logic REF_CLOCK_ENABLE_OUT,
	output logic BERT_LINK_OUT,
	output logic PORT_CONNECT_OUT,
	output logic [3:0] QUEUE_POINTER_RESET_OUT,
	output logic SELFTEST_ENABLE_OUT,
	output logic DUPLEX_SELECT_OUT,
	output logic LAPS_FRAMING_ENABLE_OUT,
	output logic SCRAMBLER_DISABLE_OUT,
	output logic BIT_ORDER_REVERSE_OUT,
	output logic [COUNT_W-1:0] RX_QUEUE_SIZE_OUT,
	output logic [COUNT_W-1:0] TX_QUEUE_SIZE_OUT,
	output logic [COUNT_W-1:0] TX_QUEUE_HIGH_OUT,
	output logic [COUNT_W-1:0] TX_QUEUE_LOW_OUT,
	output logic [COUNT_W-1:0] RX_QUEUE_LOW_OUT,
	output logic [COUNT_W-1:0] RX_QUEUE_HIGH_OUT
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic wait_r;
	logic accept;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] wdata;
	logic [7:0] rd_nxt;
	logic [7:0] rd_r;
	logic load_r;
	logic [2:0] ctrl_r;
	logic [7:0] line_ie_r;
	logic [7:0] line_is_r;
	logic [7:0] eth_ie_r;
	logic [7:0] eth_is_r;
	logic [7:0] q_ie_r;
	logic [7:0] q_is_r;
	logic [7:0] pt_ie_r;
	logic [7:0] pt_is_r;
	logic [7:0] line_ev;
	logic [7:0] eth_ev;
	logic [7:0] q_ev;
	logic [7:0] pt_ev;
	logic [7:0] strap_status_r;
	logic [7:0] queue_r [QUEUE_REGS];
	logic [COUNT_W-1:0] count_r [QUEUE_REGS];
	logic [5:0] section;

	// Only byte lane 0 carries a register; other lanes read as zero.
	assign wdata = AVS_BYTEENABLE_IN[0] ? AVS_WRITEDATA_IN[7:0] : RESET_VALUE;
	assign accept = (AVS_READ_IN || AVS_WRITE_IN) && !wait_r;
	assign wr_acc = AVS_WRITE_IN && !wait_r;
	assign rd_acc = AVS_READ_IN && !wait_r;
	assign section = AVS_ADDRESS_IN[11:SECTION_SHIFT];

	assign line_ev = {3'h0, LINE_TX_EVENT_IN, 3'h0, LINE_RX_EVENT_IN};
	assign eth_ev = {7'h00, ETHERNET_EVENT_IN};
	assign q_ev = {3'h0, TX_QUEUE_EVENT_IN, 3'h0, RX_QUEUE_EVENT_IN};
	assign pt_ev = {7'h00, PATTERN_TEST_EVENT_IN};

	// ************************************************************
	// Section decode
	// ************************************************************
	// The space splits into 64-register sections. Section 0 is global,
	// 1 arbiter, 2 pattern test, 3 and 4 serial and 5 Ethernet.
	// No register lives from section 6 upward, so a read there
	// returns zero whatever the low address bits hold. The MAC is
	// reached only indirectly and has no section of its own.
	logic mapped;
	assign mapped = (section < 6'h06);

	// ************************************************************
	// Bus handshake
	// ************************************************************
	// A request is answered one cycle after it is seen; the access
	// takes effect on the edge where waitrequest is sampled low.
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			wait_r <= 1'b1;
		end else if ((AVS_READ_IN || AVS_WRITE_IN) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rd_r <= RESET_VALUE;
		end else if (AVS_READ_IN && wait_r) begin
			rd_r <= rd_nxt;
		end
	end

	assign AVS_READDATA_OUT = {24'h000000, rd_r};
	assign AVS_WAITREQUEST_OUT = wait_r;

	// ************************************************************
	// Read decode
	// ************************************************************
	always_comb begin
		rd_nxt = RESET_VALUE;
		// Unmapped space, the unused range and MAC space read zero.
		if (mapped && AVS_ADDRESS_IN <= TOP_IDX &&
			!(AVS_ADDRESS_IN >= UNUSED_LOW_IDX &&
			AVS_ADDRESS_IN <= UNUSED_HIGH_IDX)) begin
			unique case (AVS_ADDRESS_IN)
				CHIP_ID_LOW_IDX: rd_nxt = CHIP_ID[7:0];
				CHIP_ID_HIGH_IDX: rd_nxt = CHIP_ID[15:8];
				GLOBAL_CONTROL_IDX: rd_nxt = {5'h00, ctrl_r};
				BERT_LINK_SELECT_IDX: rd_nxt = {7'h00, BERT_LINK_OUT};
				LINE_CLOCK_ACTIVITY_IDX: rd_nxt = LINE_CLOCK_ACTIVITY_IN & 8'h11;
				SYSTEM_CLOCK_ACTIVITY_IDX: rd_nxt = SYSTEM_CLOCK_ACTIVITY_IN & 8'h03;
				LINE_IRQ_ENABLE_IDX: rd_nxt = line_ie_r;
				LINE_IRQ_STATUS_IDX: rd_nxt = line_is_r;
				ETHERNET_IRQ_ENABLE_IDX: rd_nxt = eth_ie_r;
				ETHERNET_IRQ_STATUS_IDX: rd_nxt = eth_is_r;
				QUEUE_IRQ_ENABLE_IDX: rd_nxt = q_ie_r;
				QUEUE_IRQ_STATUS_IDX: rd_nxt = q_is_r;
				PATTERN_TEST_IRQ_ENABLE_IDX: rd_nxt = pt_ie_r;
				PATTERN_TEST_IRQ_STATUS_IDX: rd_nxt = pt_is_r;
				PORT_CONNECTION_IDX: rd_nxt = {7'h00, PORT_CONNECT_OUT};
				QUEUE_POINTER_RESET_IDX: rd_nxt = {4'h0, QUEUE_POINTER_RESET_OUT};
				MEMORY_SELFTEST_ENABLE_IDX: rd_nxt = {7'h00, SELFTEST_ENABLE_OUT};
				MEMORY_SELFTEST_RESULT_IDX: rd_nxt = {6'h00, SELFTEST_RESULT_IN};
				LINE_MODE_IDX: rd_nxt = {5'h00, BIT_ORDER_REVERSE_OUT,
					SCRAMBLER_DISABLE_OUT, LAPS_FRAMING_ENABLE_OUT};
				STRAP_STATUS_IDX: rd_nxt = strap_status_r;
				MAC_MODE_IDX: rd_nxt = {7'h00, DUPLEX_SELECT_OUT};
				default: begin
					for (int i = 0; i < QUEUE_REGS; i++) begin
						if (AVS_ADDRESS_IN == QUEUE_IDX[i]) begin
							rd_nxt = queue_r[i];
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Strap capture and hardware-mode load
	// ************************************************************
	// Straps are caught on the first clock after reset release.
	// They are read once only, so a strap that moves later has no
	// effect until the next reset.
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			load_r <= 1'b1;
		end else begin
			load_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			HW_MODE_OUT <= 1'b0;
			strap_status_r <= RESET_VALUE;
		end else if (load_r) begin
			HW_MODE_OUT <= STRAP_CONFIG_ENABLE_IN;
			strap_status_r <= {3'h0, STRAP_DEFAULT_SELECT_IN, LINE_ROLE_SELECT_IN,
				REDUCED_MEDIA_IF_SELECT_IN, STRAP_CONFIG_ENABLE_IN};
		end
	end

	// ************************************************************
	// Global control registers
	// ************************************************************
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_r <= 3'h0;
			BERT_LINK_OUT <= 1'b0;
			QUEUE_POINTER_RESET_OUT <= 4'h0;
			SELFTEST_ENABLE_OUT <= 1'b0;
			line_ie_r <= RESET_VALUE;
			eth_ie_r <= RESET_VALUE;
			q_ie_r <= RESET_VALUE;
			pt_ie_r <= RESET_VALUE;
		end else if (wr_acc) begin
			unique case (AVS_ADDRESS_IN)
				GLOBAL_CONTROL_IDX: ctrl_r <= wdata[2:0];
				BERT_LINK_SELECT_IDX: BERT_LINK_OUT <= wdata[0];
				QUEUE_POINTER_RESET_IDX: QUEUE_POINTER_RESET_OUT <= wdata[3:0];
				MEMORY_SELFTEST_ENABLE_IDX: SELFTEST_ENABLE_OUT <= wdata[0];
				LINE_IRQ_ENABLE_IDX: line_ie_r <= wdata & 8'h11;
				ETHERNET_IRQ_ENABLE_IDX: eth_ie_r <= wdata & 8'h01;
				QUEUE_IRQ_ENABLE_IDX: q_ie_r <= wdata & 8'h11;
				PATTERN_TEST_IRQ_ENABLE_IDX: pt_ie_r <= wdata & 8'h01;
				default: begin
				end
			endcase
		end
	end

	assign SOFT_RESET_OUT = ctrl_r[CTRL_RESET_BIT];
	assign REF_CLOCK_ENABLE_OUT = ctrl_r[CTRL_REFCLK_BIT];

	// ************************************************************
	// Strap-controlled line and MAC modes
	// ************************************************************
	// In software mode these keep their reset value until written.
	// A write that lands in the load cycle is lost, since the strap
	// load takes priority there.
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			PORT_CONNECT_OUT <= 1'b0;
			DUPLEX_SELECT_OUT <= 1'b0;
			LAPS_FRAMING_ENABLE_OUT <= 1'b0;
			SCRAMBLER_DISABLE_OUT <= 1'b0;
			BIT_ORDER_REVERSE_OUT <= 1'b0;
		end else if (load_r) begin
			if (STRAP_CONFIG_ENABLE_IN) begin
				PORT_CONNECT_OUT <= PORT_CONNECTION_HW;
				DUPLEX_SELECT_OUT <= DUPLEX_SELECT_IN;
				LAPS_FRAMING_ENABLE_OUT <= LAPS_FRAMING_ENABLE_IN;
				SCRAMBLER_DISABLE_OUT <= SCRAMBLER_DISABLE_IN;
				BIT_ORDER_REVERSE_OUT <= BIT_ORDER_REVERSE_IN;
			end
		end else if (wr_acc) begin
			unique case (AVS_ADDRESS_IN)
				PORT_CONNECTION_IDX: PORT_CONNECT_OUT <= wdata[0];
				MAC_MODE_IDX: DUPLEX_SELECT_OUT <= wdata[MAC_DUPLEX_BIT];
				LINE_MODE_IDX: begin
					LAPS_FRAMING_ENABLE_OUT <= wdata[LINE_LAPS_BIT];
					SCRAMBLER_DISABLE_OUT <= wdata[LINE_SCRAMBLER_OFF_BIT];
					BIT_ORDER_REVERSE_OUT <= wdata[LINE_BIT_REVERSE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Queue sizing registers
	// ************************************************************
	// Selector 10 picks the second set; every other code the first.
	generate
		for (genvar g = 0; g < QUEUE_REGS; g++) begin : g_queue
			always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					queue_r[g] <= RESET_VALUE;
				end else if (load_r) begin
					if (STRAP_CONFIG_ENABLE_IN) begin
						queue_r[g] <= (STRAP_DEFAULT_SELECT_IN == SELECT_SET_B) ?
							QUEUE_SET_B[g] : QUEUE_SET_A[g];
					end
				end else if (wr_acc && AVS_ADDRESS_IN == QUEUE_IDX[g]) begin
					queue_r[g] <= wdata;
				end
			end

			// Count is in packets; each packet is one SLOT_BYTES buffer slot.
			always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					count_r[g] <= '0;
				end else begin
					count_r[g] <= {queue_r[g], 5'h00};
				end
			end
		end
	endgenerate

	assign RX_QUEUE_SIZE_OUT = count_r[0];
	assign TX_QUEUE_SIZE_OUT = count_r[1];
	assign TX_QUEUE_HIGH_OUT = count_r[2];
	assign TX_QUEUE_LOW_OUT = count_r[3];
	assign RX_QUEUE_LOW_OUT = count_r[4];
	assign RX_QUEUE_HIGH_OUT = count_r[5];

	// ************************************************************
	// Latched status and interrupt
	// ************************************************************
	// Only bits actually returned by the read are cleared, and a new
	// event in the clearing cycle sets the bit again.
	// An event that arrives between the read and its completion is
	// therefore never lost.
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			line_is_r <= RESET_VALUE;
			eth_is_r <= RESET_VALUE;
			q_is_r <= RESET_VALUE;
			pt_is_r <= RESET_VALUE;
		end else begin
			line_is_r <= (line_is_r & ~((rd_acc &&
				AVS_ADDRESS_IN == LINE_IRQ_STATUS_IDX) ? rd_r : 8'h00)) | line_ev;
			eth_is_r <= (eth_is_r & ~((rd_acc &&
				AVS_ADDRESS_IN == ETHERNET_IRQ_STATUS_IDX) ? rd_r : 8'h00)) | eth_ev;
			q_is_r <= (q_is_r & ~((rd_acc &&
				AVS_ADDRESS_IN == QUEUE_IRQ_STATUS_IDX) ? rd_r : 8'h00)) | q_ev;
			pt_is_r <= (pt_is_r & ~((rd_acc &&
				AVS_ADDRESS_IN == PATTERN_TEST_IRQ_STATUS_IDX) ? rd_r : 8'h00)) | pt_ev;
		end
	end

	// The interrupt follows the status by one cycle; the mask bit in
	// global control silences it without touching the status.
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= !ctrl_r[CTRL_IRQ_MASK_BIT] && (|(line_is_r & line_ie_r) ||
				|(eth_is_r & eth_ie_r) || |(q_is_r & q_ie_r) ||
				|(pt_is_r & pt_ie_r));
		end
	end

endmodule : mapper_global_config_regs

`default_nettype wire

// ---- mapper_cfg_assertions.sv ----
// Concurrent checks on the ports of the mapper register bank.
// Assumes straps hold steady for three cycles after each reset release.
`default_nettype none

module mapper_cfg_checker
	import mapper_cfg_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic STRAP_CONFIG_ENABLE_IN,
	input wire logic [1:0] STRAP_DEFAULT_SELECT_IN,
	input wire logic HW_MODE_OUT,
	input wire logic PORT_CONNECT_OUT,
	input wire logic [COUNT_W-1:0] RX_QUEUE_SIZE_OUT,
	input wire logic [COUNT_W-1:0] TX_QUEUE_SIZE_OUT,
	input wire logic [COUNT_W-1:0] TX_QUEUE_HIGH_OUT,
	input wire logic [COUNT_W-1:0] TX_QUEUE_LOW_OUT,
	input wire logic [COUNT_W-1:0] RX_QUEUE_LOW_OUT,
	input wire logic [COUNT_W-1:0] RX_QUEUE_HIGH_OUT
);
	logic set_b;
	logic [COUNT_W-1:0] all_counts;

	assign set_b = STRAP_DEFAULT_SELECT_IN == 2'h2;
	assign all_counts = RX_QUEUE_SIZE_OUT | TX_QUEUE_SIZE_OUT | TX_QUEUE_HIGH_OUT
		| TX_QUEUE_LOW_OUT | RX_QUEUE_LOW_OUT | RX_QUEUE_HIGH_OUT;

	default clocking main_cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RST_B_IN);

	// *****
	// Bus answer
	// *****
	bus_wait_a: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
		|=> !AVS_WAITREQUEST_OUT) else $error("Access not answered after one wait cycle.");
	wait_pulse_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("Wait release lasted more than one cycle.");
	read_width_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
		|-> AVS_READDATA_OUT[31:8] == 24'h0) else $error("Read data wider than a byte.");

	// *****
	// Strap defaults and counts
	// *****
	unit_count_a: assert property (all_counts[4:0] == 5'h00)
		else $error("Queue count is not a whole number of units.");
	tx_default_a: assert property ($rose(RST_B_IN) && STRAP_CONFIG_ENABLE_IN |-> ##2
		TX_QUEUE_SIZE_OUT == {(set_b ? 8'h18 : 8'h14), 5'h00}
		&& TX_QUEUE_HIGH_OUT == {8'h0c, 5'h00} && TX_QUEUE_LOW_OUT == {8'h06, 5'h00}
		&& PORT_CONNECT_OUT) else $error("Transmit queue default wrong.");
	rx_default_a: assert property ($rose(RST_B_IN) && STRAP_CONFIG_ENABLE_IN |-> ##2
		RX_QUEUE_SIZE_OUT == {(set_b ? 8'h28 : 8'h2c), 5'h00}
		&& RX_QUEUE_LOW_OUT == {(set_b ? 8'h0c : 8'h0f), 5'h00}
		&& RX_QUEUE_HIGH_OUT == {(set_b ? 8'h18 : 8'h1e), 5'h00})
		else $error("Receive queue default wrong.");
	soft_default_a: assert property ($rose(RST_B_IN) && !STRAP_CONFIG_ENABLE_IN |-> ##2
		all_counts == '0 && !PORT_CONNECT_OUT) else $error("Software mode default not zero.");
	mode_flag_a: assert property ($rose(RST_B_IN) |=>
		HW_MODE_OUT == $past(STRAP_CONFIG_ENABLE_IN)) else $error("Hardware mode flag wrong.");

endmodule : mapper_cfg_checker

bind mapper_global_config_regs mapper_cfg_checker chk_i (.CLK_SYS_IN(CLK_SYS_IN),
	.RST_B_IN(RST_B_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
	.AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.STRAP_CONFIG_ENABLE_IN(STRAP_CONFIG_ENABLE_IN),
	.STRAP_DEFAULT_SELECT_IN(STRAP_DEFAULT_SELECT_IN), .HW_MODE_OUT(HW_MODE_OUT),
	.PORT_CONNECT_OUT(PORT_CONNECT_OUT), .RX_QUEUE_SIZE_OUT(RX_QUEUE_SIZE_OUT),
	.TX_QUEUE_SIZE_OUT(TX_QUEUE_SIZE_OUT), .TX_QUEUE_HIGH_OUT(TX_QUEUE_HIGH_OUT),
	.TX_QUEUE_LOW_OUT(TX_QUEUE_LOW_OUT), .RX_QUEUE_LOW_OUT(RX_QUEUE_LOW_OUT),
	.RX_QUEUE_HIGH_OUT(RX_QUEUE_HIGH_OUT));

`default_nettype wire

// ---- mapper_strap_model.sv ----
// Strap pins of a board that runs the mapper without a host.
// Assumes the bench changes the setting only while reset is held.
`default_nettype none

module mapper_strap_model (
	input wire logic [8:0] setting_in,
	output logic hw_mode_out,
	output logic [1:0] select_out,
	output logic media_out,
	output logic role_out,
	output logic duplex_out,
	output logic laps_out,
	output logic scrambler_off_out,
	output logic bit_reverse_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Each pin is a plain level taken from one bit of the setting.
	assign {bit_reverse_out, scrambler_off_out, laps_out, duplex_out, role_out, media_out,
		select_out, hw_mode_out} = setting_in;

endmodule : mapper_strap_model

`default_nettype wire

// ---- mapper_global_config_regs_tb.sv ----
// Self-checking bench for the mapper register bank.
// Assumes a 100 MHz clock and the strap model on the strap pins.
`default_nettype none

module mapper_global_config_regs_tb
	import mapper_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] ID = 16'h3c7e; // Arbitrary value.
	localparam logic [7:0] SET_A [6] = '{8'h2c, 8'h14, 8'h0c, 8'h06, 8'h0f, 8'h1e};
	localparam logic [7:0] SET_B [6] = '{8'h28, 8'h18, 8'h0c, 8'h06, 8'h0c, 8'h18};
	localparam logic [11:0] HOLES [5] = '{12'h180, 12'h7ff, 12'h900, 12'h140, 12'h03f};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [8:0] strap = 9'h000;
	logic [7:0] act = 8'h00;
	logic [5:0] ev = 6'h00;
	logic [31:0] rdata;
	logic [7:0] q;
	logic [1:0] sel;
	logic waitreq, irq, duplex, laps, scr_off, brev, hw_en, media, role, dsel, lsel, ssel, bsel;
	logic hw_mode, srst, refclk;
	logic [COUNT_W-1:0] rx_size, tx_size;
	int fail_count = 0;
	int check_count = 0;
	int seed = 52;

	always #5 clk = ~clk;

	mapper_strap_model straps (.setting_in(strap), .hw_mode_out(hw_en), .select_out(sel),
		.media_out(media), .role_out(role), .duplex_out(dsel), .laps_out(lsel),
		.scrambler_off_out(ssel), .bit_reverse_out(bsel));

	mapper_global_config_regs #(.CHIP_ID(ID)) dut (
		.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
		.STRAP_CONFIG_ENABLE_IN(hw_en), .STRAP_DEFAULT_SELECT_IN(sel),
		.REDUCED_MEDIA_IF_SELECT_IN(media), .LINE_ROLE_SELECT_IN(role),
		.DUPLEX_SELECT_IN(dsel), .LAPS_FRAMING_ENABLE_IN(lsel),
		.SCRAMBLER_DISABLE_IN(ssel), .BIT_ORDER_REVERSE_IN(bsel),
		.LINE_CLOCK_ACTIVITY_IN(act), .SYSTEM_CLOCK_ACTIVITY_IN(~act),
		.SELFTEST_RESULT_IN(act[1:0]), .LINE_TX_EVENT_IN(ev[5]), .LINE_RX_EVENT_IN(ev[4]),
		.ETHERNET_EVENT_IN(ev[3]), .TX_QUEUE_EVENT_IN(ev[2]), .RX_QUEUE_EVENT_IN(ev[1]),
		.PATTERN_TEST_EVENT_IN(ev[0]), .IRQ_OUT(irq), .HW_MODE_OUT(hw_mode),
		.SOFT_RESET_OUT(srst), .REF_CLOCK_ENABLE_OUT(refclk), .BERT_LINK_OUT(),
		.PORT_CONNECT_OUT(),
		.QUEUE_POINTER_RESET_OUT(), .SELFTEST_ENABLE_OUT(), .DUPLEX_SELECT_OUT(duplex),
		.LAPS_FRAMING_ENABLE_OUT(laps), .SCRAMBLER_DISABLE_OUT(scr_off),
		.BIT_ORDER_REVERSE_OUT(brev), .RX_QUEUE_SIZE_OUT(rx_size), .TX_QUEUE_SIZE_OUT(tx_size),
		.TX_QUEUE_HIGH_OUT(), .TX_QUEUE_LOW_OUT(), .RX_QUEUE_LOW_OUT(), .RX_QUEUE_HIGH_OUT());

	// *****
	// Tasks and expectations
	// *****
	task automatic print_verdict;
		if (fail_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : compare

	// Holds the request until waitrequest is seen low at a rising edge.
	task automatic access(input logic write, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		rd <= !write;
		wr <= write;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 40);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 40) begin
			fail_count++;
			$display("Error at %0t ns: got %h, expected %h", $time, waitreq, 1'b0);
		end
	endtask : access

	task automatic expect_reg(input logic [11:0] a, input logic [7:0] e);
		access(1'b0, a, 8'h00);
		compare({24'h0, q}, {24'h0, e});
	endtask : expect_reg

	task automatic restart(input logic [8:0] s);
		rst_b <= 1'b0;
		strap <= s;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : restart

	task automatic pulse(input logic [5:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 6'h00;
		repeat (3) @(posedge clk);
	endtask : pulse

	function automatic logic [7:0] queue_default(input int i, input logic [8:0] s);
		if (!s[0]) begin
			return 8'h00;
		end
		return (s[2:1] == 2'h2) ? SET_B[i] : SET_A[i];
	endfunction : queue_default

	// *****
	// Main sequence
	// *****
	initial begin
		logic [8:0] s;
		logic [7:0] v;
		for (int k = 0; k < 9; k++) begin
			s = 9'($random(seed));
			s[0] = k < 8;
			s[2:1] = 2'(k);
			act <= 8'($random(seed));
			restart(s);
			for (int i = 0; i < QUEUE_REGS; i++) begin
				expect_reg(QUEUE_IDX[i], queue_default(i, s));
			end
			compare(32'({rx_size, tx_size}), 32'({queue_default(0, s), 5'h00, queue_default(1, s),
				5'h00}));
			expect_reg(PORT_CONNECTION_IDX, {7'h0, s[0]});
			expect_reg(LINE_MODE_IDX, s[0] ? {5'h0, s[8:6]} : 8'h00);
			expect_reg(MAC_MODE_IDX, {7'h0, s[0] & s[5]});
			expect_reg(STRAP_STATUS_IDX, {3'h0, s[2:1], s[4], s[3], s[0]});
			compare(32'(hw_mode), 32'(s[0]));
			compare({28'h0, duplex, laps, scr_off, brev}, s[0] ? {28'h0, s[5], s[6], s[7], s[8]}
				: 32'h0);
		end
		repeat (4) begin
			v = 8'($random(seed));
			access(1'b1, QUEUE_IDX[1], v);
			expect_reg(QUEUE_IDX[1], v);
			compare(32'(tx_size), {19'h0, v, 5'h00});
		end
		for (int j = 0; j < 5; j++) begin
			access(1'b1, HOLES[j], 8'hff);
			expect_reg(HOLES[j], 8'h00);
		end
		access(1'b1, 12'h00f, 8'h00);
		expect_reg(LINE_CLOCK_ACTIVITY_IDX, act & 8'h11);
		expect_reg(SYSTEM_CLOCK_ACTIVITY_IDX, ~act & 8'h03);
		expect_reg(MEMORY_SELFTEST_RESULT_IDX, {6'h0, act[1:0]});
		access(1'b1, GLOBAL_CONTROL_IDX, 8'h05);
		expect_reg(GLOBAL_CONTROL_IDX, 8'h05);
		compare({30'h0, refclk, srst}, 32'h3);
		access(1'b1, CHIP_ID_LOW_IDX, 8'hff);
		expect_reg(CHIP_ID_LOW_IDX, ID[7:0]);
		expect_reg(CHIP_ID_HIGH_IDX, ID[15:8]);
		access(1'b1, QUEUE_IRQ_ENABLE_IDX, 8'h10);
		pulse(6'h04);
		compare(32'(irq), 32'h1);
		expect_reg(QUEUE_IRQ_STATUS_IDX, 8'h10);
		expect_reg(QUEUE_IRQ_STATUS_IDX, 8'h00);
		repeat (2) @(posedge clk);
		compare(32'(irq), 32'h0);
		pulse(6'h02);
		compare(32'(irq), 32'h0);
		expect_reg(QUEUE_IRQ_STATUS_IDX, 8'h01);
		print_verdict;
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict;
	end

endmodule : mapper_global_config_regs_tb

`default_nettype wire
